// *** logic/wcm_cfg.svh ***
// Timing constants and encodings for the wake-up clock masking block.
`ifndef WCM_CFG_SVH
`define WCM_CFG_SVH
`define WCM_CLK_MHZ            125
`define WCM_OVERSHOOT_US       6
`define WCM_LONG_MASK_US       150
`define WCM_SHORT_MASK_US      2
`define WCM_OUT_OF_SPEC_US     4
`define WCM_OVERSHOOT_CYC      (`WCM_OVERSHOOT_US * `WCM_CLK_MHZ)
`define WCM_LONG_MASK_CYC      (`WCM_LONG_MASK_US * `WCM_CLK_MHZ)
`define WCM_SHORT_MASK_CYC     (`WCM_SHORT_MASK_US * `WCM_CLK_MHZ)
`define WCM_CNT_W              16
`define WCM_DIV_W              3
`define WCM_DIV_BY_TWO         3'h1
`define WCM_DIV_NONE           3'h0
`define WCM_VLEVEL_W           2
`define WCM_ADDR_W             4
`define WCM_ADDR_DIV_CTRL      4'h0
`define WCM_ADDR_REQ_CTRL      4'h1
`define WCM_ADDR_SUPV_CTRL     4'h2
`define WCM_ADDR_STATUS        4'h3
`define WCM_ADDR_FAST_LIMIT    4'h4
`define WCM_SUPV_RESET         4'h5
`define WCM_FAST_LIMIT_RESET   16'h0005
`endif

// *** logic/wcm_pkg.sv ***
// Types for the wake-up clock masking block.
package wcm_pkg;
  typedef enum logic [2:0] {
    WCM_RUN   = 3'h1,
    WCM_SLEEP = 3'h2,
    WCM_MASK  = 3'h4
  } wcm_state_e;
endpackage

// *** logic/wcm_timer.sv ***
// Load-and-count-down interval timer with an expiry flag.
`timescale 1ns/1ns
`default_nettype none
module wcm_timer #(
  parameter int W = 16
) (
  input  wire logic         core_clk,
  input  wire logic         srst,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  output logic              busy,
  output logic              done
);
  logic [W-1:0] cnt_reg;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      cnt_reg <= '0;
      busy    <= 1'b0;
      done    <= 1'b0;
    end else if (load) begin
      cnt_reg <= load_val;
      busy    <= (load_val != '0);
      done    <= (load_val == '0);
    end else if (busy) begin
      cnt_reg <= cnt_reg - W'(1);
      busy    <= (cnt_reg > W'(1));
      done    <= (cnt_reg == W'(1));
    end else begin
      done    <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// *** logic/wcm_top.sv ***
// Wake-up clock masking for the core clock after deep sleep, with subsystem clock gating during sleep.
`timescale 1ns/1ns
`default_nettype none
`include "wcm_cfg.svh"
module wcm_top #(
  parameter int LONG_MASK_CYC = `WCM_LONG_MASK_CYC,
  parameter int SHORT_MASK_CYC = `WCM_SHORT_MASK_CYC,
  parameter int OVERSHOOT_CYC = `WCM_OVERSHOOT_CYC
) (
  input  wire logic                     core_clk,
  input  wire logic                     srst,
  input  wire logic                     sleep_req,
  input  wire logic                     wake_req,
  input  wire logic [`WCM_ADDR_W-1:0]   reg_addr,
  input  wire logic [15:0]              reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output logic      [15:0]              reg_rdata,
  output logic                          cpu_clk_en,
  output logic                          sleeping,
  output logic                          oscillator_overshoot,
  output logic                          subsystem_clk_en,
  output logic                          core_out_of_spec,
  output logic      [`WCM_DIV_W-1:0]    core_clock_divider_field
);
  wcm_pkg::wcm_state_e       state_reg;
  wcm_pkg::wcm_state_e       state_next;
  logic [2:0]                sleep_sync;
  logic [2:0]                wake_sync;
  logic                      sleep_pulse;
  logic                      wake_pulse;
  logic                      subsystem_clock_request_enable;
  logic                      sub_from_crystal;
  logic                      low_supervisor_enable_bit;
  logic                      low_monitor_enable_bit;
  logic                      low_supervisor_full_perf_bit;
  logic                      low_monitor_full_perf_bit;
  logic [`WCM_VLEVEL_W-1:0]  core_vlevel;
  logic [15:0]               fast_limit_mhz;
  logic [15:0]               dco_mhz;
  logic                      short_mask;
  logic                      mask_load;
  logic                      mask_busy;
  logic                      mask_done;
  logic                      ovs_busy;
  logic [`WCM_CNT_W-1:0]     mask_len;
  logic [7:0]                wake_count_reg;

  // Sleep and wake requests come from pins; two flops before any edge detection.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      sleep_sync <= 3'h0;
      wake_sync  <= 3'h0;
    end else begin
      sleep_sync <= {sleep_sync[1:0], sleep_req};
      wake_sync  <= {wake_sync[1:0], wake_req};
    end
  end

  assign sleep_pulse = sleep_sync[1] & ~sleep_sync[2];
  assign wake_pulse  = wake_sync[1] & ~wake_sync[2];

  // Short mask when both are off or both run in full performance.
  assign short_mask = (~low_supervisor_enable_bit & ~low_monitor_enable_bit) |
                      (low_supervisor_full_perf_bit & low_monitor_full_perf_bit);
  assign mask_len = short_mask ? `WCM_CNT_W'(SHORT_MASK_CYC)
                               : `WCM_CNT_W'(LONG_MASK_CYC);
  assign mask_load = (state_reg == wcm_pkg::WCM_SLEEP) && wake_pulse;

  wcm_timer #(.W(`WCM_CNT_W)) u_mask_timer (
    .core_clk (core_clk),
    .srst     (srst),
    .load     (mask_load),
    .load_val (mask_len),
    .busy     (mask_busy),
    .done     (mask_done)
  );

  wcm_timer #(.W(`WCM_CNT_W)) u_ovs_timer (
    .core_clk (core_clk),
    .srst     (srst),
    .load     (mask_load),
    .load_val (`WCM_CNT_W'(OVERSHOOT_CYC)),
    .busy     (ovs_busy),
    .done     ()
  );

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      wcm_pkg::WCM_RUN: begin
        if (sleep_pulse) begin
          state_next = wcm_pkg::WCM_SLEEP;
        end
      end
      wcm_pkg::WCM_SLEEP: begin
        if (wake_pulse) begin
          state_next = wcm_pkg::WCM_MASK;
        end
      end
      wcm_pkg::WCM_MASK: begin
        if (mask_done) begin
          state_next = wcm_pkg::WCM_RUN;
        end
      end
      default: state_next = wcm_pkg::WCM_RUN;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_reg <= wcm_pkg::WCM_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  // CPU clock gate opens only once the selected mask has fully run out.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      cpu_clk_en <= 1'b1;
      sleeping   <= 1'b0;
    end else begin
      cpu_clk_en <= (state_next == wcm_pkg::WCM_RUN);
      sleeping   <= (state_next != wcm_pkg::WCM_RUN);
    end
  end

  // The subsystem clock follows the oscillator with no wake-up mask.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      subsystem_clk_en     <= 1'b1;
      oscillator_overshoot <= 1'b0;
    end else begin
      subsystem_clk_en     <= subsystem_clock_request_enable |
                              (state_next != wcm_pkg::WCM_SLEEP);
      oscillator_overshoot <= ovs_busy | mask_load;
    end
  end

  // Undivided fast core clock during a short mask overshoot is out of spec.
  assign dco_mhz = 16'(`WCM_CLK_MHZ);
  always_ff @(posedge core_clk) begin
    if (srst) begin
      core_out_of_spec <= 1'b0;
    end else begin
      core_out_of_spec <= short_mask && ovs_busy && !mask_busy &&
                          (core_clock_divider_field == `WCM_DIV_NONE) &&
                          (dco_mhz > fast_limit_mhz);
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      wake_count_reg <= 8'h00;
    end else if (mask_done) begin
      wake_count_reg <= wake_count_reg + 8'h01;
    end
  end

  // Software-visible control; divider and request enable are kept by software.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      core_clock_divider_field       <= `WCM_DIV_NONE;
      subsystem_clock_request_enable <= 1'b1;
      sub_from_crystal               <= 1'b0;
      {low_supervisor_enable_bit, low_monitor_enable_bit,
       low_supervisor_full_perf_bit, low_monitor_full_perf_bit} <= `WCM_SUPV_RESET;
      core_vlevel                    <= '0;
      fast_limit_mhz                 <= `WCM_FAST_LIMIT_RESET;
    end else if (reg_wr) begin
      unique case (reg_addr)
        `WCM_ADDR_DIV_CTRL: begin
          core_clock_divider_field <= reg_wdata[`WCM_DIV_W-1:0];
          core_vlevel              <= reg_wdata[9:8];
        end
        `WCM_ADDR_REQ_CTRL: begin
          subsystem_clock_request_enable <= reg_wdata[0];
          sub_from_crystal               <= reg_wdata[1];
        end
        `WCM_ADDR_SUPV_CTRL: begin
          {low_supervisor_enable_bit, low_monitor_enable_bit,
           low_supervisor_full_perf_bit, low_monitor_full_perf_bit} <= reg_wdata[3:0];
        end
        `WCM_ADDR_FAST_LIMIT: begin
          fast_limit_mhz <= reg_wdata;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `WCM_ADDR_DIV_CTRL:   reg_rdata <= {6'h00, core_vlevel, 5'h00, core_clock_divider_field};
        `WCM_ADDR_REQ_CTRL:   reg_rdata <= {14'h0000, sub_from_crystal,
                                            subsystem_clock_request_enable};
        `WCM_ADDR_SUPV_CTRL:  reg_rdata <= {12'h000, low_supervisor_enable_bit,
                                            low_monitor_enable_bit,
                                            low_supervisor_full_perf_bit,
                                            low_monitor_full_perf_bit};
        `WCM_ADDR_STATUS:     reg_rdata <= {wake_count_reg, 2'h0, short_mask, core_out_of_spec,
                                            oscillator_overshoot, mask_busy, sleeping,
                                            cpu_clk_en};
        `WCM_ADDR_FAST_LIMIT: reg_rdata <= fast_limit_mhz;
        default:              reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end
endmodule
`default_nettype wire

// *** bench/wcm_chk.sv ***
// Assertion checker for the wake-up clock masking block.
`timescale 1ns/1ns
`default_nettype none
module wcm_chk #(
  parameter int LONG_MASK_CYC  = 20,
  parameter int SHORT_MASK_CYC = 4,
  parameter int OVERSHOOT_CYC  = 8
) (
  input wire logic       core_clk,
  input wire logic       srst,
  input wire logic       cpu_clk_en,
  input wire logic       sleeping,
  input wire logic       oscillator_overshoot,
  input wire logic       subsystem_clk_en,
  input wire logic       core_out_of_spec,
  input wire logic [2:0] core_clock_divider_field
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  logic [15:0] ov_cnt;
  logic [15:0] wk_cnt;
  // Counts overshoot cycles and cycles since the overshoot began at wake-up.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ov_cnt <= 16'h0000;
      wk_cnt <= 16'h0000;
    end else begin
      ov_cnt <= oscillator_overshoot ? ov_cnt + 16'h0001 : 16'h0000;
      wk_cnt <= (oscillator_overshoot && ov_cnt == 16'h0000) ? 16'h0001 : wk_cnt + 16'h0001;
    end
  end
  sequence s_release;
    $rose(cpu_clk_en);
  endsequence
  AST_OVERSHOOT_SPAN: assert property ($fell(oscillator_overshoot) |->
    ov_cnt == OVERSHOOT_CYC + 1) else $error("overshoot span wrong");
  AST_LONG_MASK: assert property (s_release ##0 !oscillator_overshoot |->
    wk_cnt inside {[LONG_MASK_CYC - 2:LONG_MASK_CYC + 4]}) else $error("long mask length wrong");
  AST_SHORT_MASK: assert property (s_release ##0 oscillator_overshoot |->
    wk_cnt inside {[SHORT_MASK_CYC - 2:SHORT_MASK_CYC + 4]}) else $error("short mask length wrong");
  AST_OUT_OF_SPEC: assert property (core_out_of_spec |->
    cpu_clk_en && oscillator_overshoot && core_clock_divider_field == 3'h0)
    else $error("out of spec flag without cause");
  AST_SUBSYS_UNMASKED: assert property (oscillator_overshoot |-> subsystem_clk_en)
    else $error("subsystem clock masked on wake");
  AST_HOLD_IN_SLEEP: assert property (sleeping |-> !cpu_clk_en)
    else $error("core clock released during sleep or mask");
  AST_NO_EARLY_RELEASE: assert property ($fell(sleeping) |->
    wk_cnt > SHORT_MASK_CYC) else $error("core clock released before the mask ran out");
endmodule
bind wcm_top wcm_chk #(.LONG_MASK_CYC(LONG_MASK_CYC), .SHORT_MASK_CYC(SHORT_MASK_CYC),
  .OVERSHOOT_CYC(OVERSHOOT_CYC)) i_wcm_chk (.core_clk(core_clk), .srst(srst),
  .cpu_clk_en(cpu_clk_en), .sleeping(sleeping), .oscillator_overshoot(oscillator_overshoot),
  .subsystem_clk_en(subsystem_clk_en), .core_out_of_spec(core_out_of_spec),
  .core_clock_divider_field(core_clock_divider_field));
`default_nettype wire

// *** bench/tb.sv ***
// Self-checking testbench for the wake-up clock masking block.
`timescale 1ns/1ns
`default_nettype none
module tb;
  localparam int LM = 20;
  localparam int SM = 4;
  localparam int OV = 8;
  logic        core_clk, srst, sleep_req, wake_req, reg_wr, reg_rd;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, rv;
  logic        cpu_en, slp, ovs, ssc, oos;
  logic [2:0]  div;
  int          n_mismatch, total_checks;
  wcm_top #(.LONG_MASK_CYC(LM), .SHORT_MASK_CYC(SM), .OVERSHOOT_CYC(OV)) i_wcm_top (
    .core_clk(core_clk), .srst(srst), .sleep_req(sleep_req), .wake_req(wake_req),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .cpu_clk_en(cpu_en), .sleeping(slp),
    .oscillator_overshoot(ovs), .subsystem_clk_en(ssc), .core_out_of_spec(oos),
    .core_clock_divider_field(div));
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(posedge core_clk);
    d = reg_rdata;
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Sleeps, wakes and watches release time, overshoot span and clock flags.
  task automatic run_wake(input logic [15:0] supv, input logic [15:0] dv, input logic req,
                          input int lo, input int hi, input logic exp_oos);
    int n, rel, ov;
    logic seen_oos, ss_low;
    rel = 0; ov = 0; seen_oos = 1'b0; ss_low = 1'b0;
    wr(4'h2, supv);
    wr(4'h0, dv);
    wr(4'h1, {15'h0000, req});
    @(posedge core_clk);
    sleep_req <= 1'b1;
    repeat (3) @(posedge core_clk);
    sleep_req <= 1'b0;
    repeat (6) @(posedge core_clk);
    check("sleeping", 16'h0001, {15'h0000, slp});
    check("cpu_en_sleep", 16'h0000, {15'h0000, cpu_en});
    check("ss_sleep", {15'h0000, req}, {15'h0000, ssc});
    wake_req <= 1'b1;
    for (n = 1; n <= 60; n++) begin
      @(posedge core_clk);
      if (cpu_en === 1'b1 && rel == 0) rel = n;
      if (ovs === 1'b1) ov++;
      if (oos === 1'b1) seen_oos = 1'b1;
      if (ovs === 1'b1 && ssc !== 1'b1) ss_low = 1'b1;
    end
    wake_req <= 1'b0;
    check("release_in_window", 16'h0001, {15'h0000, rel >= lo && rel <= hi});
    check("overshoot_cycles", 16'(OV + 1), 16'(ov));
    check("ss_masked", 16'h0000, {15'h0000, ss_low});
    check("out_of_spec", {15'h0000, exp_oos}, {15'h0000, seen_oos});
    $display("wake test supv %h div %h done", supv, dv);
  endtask
  task automatic t_regs();
    rd(4'h2, rv);
    check("supv_reset", 16'h0005, rv);
    rd(4'h4, rv);
    check("limit_reset", 16'h0005, rv);
    rd(4'h1, rv);
    check("req_reset", 16'h0001, rv);
    rd(4'h3, rv);
    check("status_reset", 16'h0001, rv);
    wr(4'hF, 16'hFFFF);
    rd(4'hF, rv);
    check("unmapped", 16'h0000, rv);
    $display("register test done");
  endtask
  // Runs after a divided wake; the wake loop has already waited well past 32 cycles.
  task automatic t_restore();
    check("div_before", 16'h0001, {13'h0000, div});
    check("ovs_settled", 16'h0000, {15'h0000, ovs});
    wr(4'h0, 16'h0000);
    wr(4'h1, 16'h0001);
    rd(4'h0, rv);
    check("div_cleared", 16'h0000, rv);
    check("div_out", 16'h0000, {13'h0000, div});
    check("ss_reenabled", 16'h0001, {15'h0000, ssc});
    $display("restore test done");
  endtask
  initial begin
    srst = 1'b1; sleep_req = 1'b0; wake_req = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0;
    reg_addr = 4'h0; reg_wdata = 16'h0000; n_mismatch = 0; total_checks = 0;
    repeat (5) @(posedge core_clk);
    srst <= 1'b0;
    t_regs();
    run_wake(16'h0005, 16'h0000, 1'b1, LM + 3, LM + 6, 1'b0);
    run_wake(16'h0000, 16'h0000, 1'b0, SM + 3, SM + 6, 1'b1);
    run_wake(16'h000F, 16'h0001, 1'b0, SM + 3, SM + 6, 1'b0);
    t_restore();
    run_wake(16'h0008, 16'h0000, 1'b1, LM + 3, LM + 6, 1'b0);
    rd(4'h3, rv);
    check("wake_count", 16'h0401, rv & 16'hFF01);
    print_verdict();
  end
  initial begin
    repeat (3000) @(posedge core_clk);
    n_mismatch++;
    print_verdict();
  end
endmodule
`default_nettype wire
